// file: rtl/dcnt_pkg.sv
// Purpose: Shared constants for the dual up/down compare counter.
// Assumes: 32-bit AXI4-Lite register access, 25 MHz core clock.
// Notes: Counter B registers sit one bank above counter A.
package dcnt_pkg;
	localparam int NUM_CNT = 2;
	localparam int DW = 32;
	localparam int AW = 8;

	// Register map, word indices inside one bank
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_CFG = 3'h1;
	localparam logic [2:0] IDX_RSTVAL = 3'h2;
	localparam logic [2:0] IDX_PEND = 3'h3;
	localparam logic [2:0] IDX_COUNT = 3'h4;
	localparam logic [2:0] IDX_COMP = 3'h5;
	localparam logic [2:0] IDX_STATUS = 3'h6;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 4;
	localparam int BANK_BIT = 5;
	localparam int MAP_TOP = 7;

	// Control register fields
	localparam int CTRL_GATE = 0;
	localparam int CTRL_RESET = 1;
	localparam int CTRL_SETCMP = 2;
	localparam int CTRL_XCHG = 3;
	localparam logic [3:0] CTRL_RST_VAL = 4'h8;

	// Configuration register fields
	localparam int CFG_MODE = 0;
	localparam int CFG_RUP_LSB = 2;
	localparam int CFG_RDN_LSB = 4;
	localparam int CFG_RST_UP = 6;
	localparam int CFG_RST_DN = 7;
	localparam int CFG_LD_UP = 8;
	localparam int CFG_LD_DN = 9;
	localparam int CFG_W = 10;
	localparam logic [9:0] CFG_RST_VAL = 10'h000;

	localparam logic [31:0] RSTVAL_DEF = 32'h0000_0000;
	localparam logic [31:0] PEND_DEF = 32'h0000_0000;
	localparam logic [31:0] COMP_DEF = 32'h0000_0000;
	localparam logic [31:0] ONE = 32'h0000_0001;

	// Output reaction on a compare event
	localparam logic [1:0] REACT_NONE = 2'h0;
	localparam logic [1:0] REACT_ON = 2'h1;
	localparam logic [1:0] REACT_TOGGLE = 2'h2;
	localparam logic [1:0] REACT_OFF = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/dcnt_channel.sv
// Purpose: One 32-bit up/down counter with comparator and one output.
// Assumes: Counting pins are asynchronous; control comes from core_clk logic.
// Notes: Wraps naturally through two's complement at both ends.
`timescale 1ns/1ps
module dcnt_channel (
	input wire logic core_clk, // Core clock
	input wire logic nrst, // Async reset, active low
	input wire logic up_pin, // Up or pulse pin
	input wire logic dn_pin, // Down or direction pin
	input wire logic gate, // Count gate
	input wire logic hold_rst, // Level reset to reset value
	input wire logic set_comp, // Compare load strobe, rising edge
	input wire logic mode, // 0 up/down, 1 pulse/direction
	input wire logic [1:0] react_up, // Reaction on reach from below
	input wire logic [1:0] react_dn, // Reaction on fall below
	input wire logic rst_on_up, // Reset count on reach from below
	input wire logic rst_on_dn, // Reset count on fall below
	input wire logic ld_on_up, // Load comparator on reach from below
	input wire logic ld_on_dn, // Load comparator on fall below
	input wire logic [31:0] reset_value, // Reset value
	input wire logic [31:0] pending_compare_value, // New comparison value
	output logic [31:0] count, // Actual value
	output logic [31:0] comp, // Active comparison value
	output logic out_pin // Digital output
);
	logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d, rise;
	logic [31:0] count_q, comp_q, count_next;
	logic out_q, sc_q, inc, dec, hit_up, hit_dn;

	// Three stages; a change is accepted once stages two and three agree
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			filt_q <= 2'h0;
		end else begin
			s1_q <= {dn_pin, up_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		end
		rise = filt_d & ~filt_q;
	end

	// Direction level is sampled as filtered, so a skewed edge is not miscounted
	always_comb begin
		if (mode) begin
			inc = rise[0] & filt_d[1];
			dec = rise[0] & ~filt_d[1];
		end else begin
			inc = rise[0] & ~rise[1];
			dec = rise[1] & ~rise[0];
		end
		inc = inc & gate & ~hold_rst;
		dec = dec & gate & ~hold_rst;
		count_next = inc ? count_q + dcnt_pkg::ONE : count_q - dcnt_pkg::ONE;
		hit_up = inc && (count_next == comp_q);
		hit_dn = dec && (count_q == comp_q);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= dcnt_pkg::RSTVAL_DEF;
		end else if (hold_rst) begin
			count_q <= reset_value;
		end else if ((hit_up && rst_on_up) || (hit_dn && rst_on_dn)) begin
			count_q <= reset_value;
		end else if (inc || dec) begin
			count_q <= count_next;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sc_q <= 1'b0;
			comp_q <= dcnt_pkg::COMP_DEF;
		end else begin
			sc_q <= set_comp;
			if (set_comp && !sc_q) begin
				comp_q <= pending_compare_value;
			end else if ((hit_up && ld_on_up) || (hit_dn && ld_on_dn)) begin
				comp_q <= pending_compare_value;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			out_q <= 1'b0;
		end else if (hold_rst) begin
			out_q <= 1'b0;
		end else if (hit_up || hit_dn) begin
			case (hit_up ? react_up : react_dn)
				dcnt_pkg::REACT_ON: out_q <= 1'b1;
				dcnt_pkg::REACT_TOGGLE: out_q <= ~out_q;
				dcnt_pkg::REACT_OFF: out_q <= 1'b0;
				default: out_q <= out_q;
			endcase
		end
	end

	assign count = count_q;
	assign comp = comp_q;
	assign out_pin = out_q;
endmodule // dcnt_channel

// file: rtl/dcnt_top.sv
// Purpose: Dual independent up/down compare counter with AXI4-Lite registers.
// Assumes: 25 MHz core_clk, counting pins asynchronous to it.
// Notes: Counter A is bank 0, counter B bank 1 of the register map.
//
// Notes on behaviour
// - Two identical, fully independent counters.
// - A uses pins 0,1; B uses 2,3.
// - Each counter drives exactly one output.
// - Exchange enable gates both control and data exchange.
// - Gate low ignores pulses; high counts them.
// - Reset control holds count at reset value.
// - Reset control forces output low, ignores compares.
// - Rising load strobe activates pending compare value.
// - Compare event, if enabled for its direction, also activates pending compare value.
// - Compare values are full signed 32-bit.
// - Pulse mode: direction high up, low down.
// - Count wraps at maximum and minimum.
// - Compare reaction: none, on, toggle, off.
`timescale 1ns/1ps
module dcnt_top (
	input wire logic core_clk, // Core clock, 25 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic a_up_pulse, // Counter A up or pulse pin
	input wire logic a_down_dir, // Counter A down or direction pin
	input wire logic b_up_pulse, // Counter B up or pulse pin
	input wire logic b_down_dir, // Counter B down or direction pin
	output logic a_out, // Counter A digital output
	output logic b_out, // Counter B digital output
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	localparam int N = dcnt_pkg::NUM_CNT;

	// Software-side registers
	logic [3:0] ctrl_q [N];
	logic [dcnt_pkg::CFG_W-1:0] cfg_q [N];
	logic [31:0] rstval_q [N];
	logic [31:0] pend_q [N];
	// Values handed to and from the counters while exchange is enabled
	logic [2:0] app_ctrl_q [N];
	logic [31:0] app_pend_q [N];
	logic [31:0] snap_count_q [N];
	logic [31:0] snap_comp_q [N];
	logic [31:0] cnt_val [N];
	logic [31:0] cmp_val [N];
	logic [N-1:0] up_pins, dn_pins, outs;

	assign up_pins = {b_up_pulse, a_up_pulse};
	assign dn_pins = {b_down_dir, a_down_dir};
	assign a_out = outs[0];
	assign b_out = outs[1];

	// Each counter owns its own registers and logic; nothing is shared
	for (genvar g = 0; g < N; g++) begin : g_cnt
		dcnt_channel u_chan (
			.core_clk(core_clk),
			.nrst(nrst),
			.up_pin(up_pins[g]),
			.dn_pin(dn_pins[g]),
			.gate(app_ctrl_q[g][dcnt_pkg::CTRL_GATE]),
			.hold_rst(app_ctrl_q[g][dcnt_pkg::CTRL_RESET]),
			.set_comp(app_ctrl_q[g][dcnt_pkg::CTRL_SETCMP]),
			.mode(cfg_q[g][dcnt_pkg::CFG_MODE]),
			.react_up(cfg_q[g][dcnt_pkg::CFG_RUP_LSB +: 2]),
			.react_dn(cfg_q[g][dcnt_pkg::CFG_RDN_LSB +: 2]),
			.rst_on_up(cfg_q[g][dcnt_pkg::CFG_RST_UP]),
			.rst_on_dn(cfg_q[g][dcnt_pkg::CFG_RST_DN]),
			.ld_on_up(cfg_q[g][dcnt_pkg::CFG_LD_UP]),
			.ld_on_dn(cfg_q[g][dcnt_pkg::CFG_LD_DN]),
			.reset_value(rstval_q[g]),
			.pending_compare_value(app_pend_q[g]),
			.count(cnt_val[g]),
			.comp(cmp_val[g]),
			.out_pin(outs[g])
		);

		// Clearing exchange enable freezes the control and data paths, never the counter itself
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				app_ctrl_q[g] <= dcnt_pkg::CTRL_RST_VAL[2:0];
				app_pend_q[g] <= dcnt_pkg::PEND_DEF;
				snap_count_q[g] <= dcnt_pkg::RSTVAL_DEF;
				snap_comp_q[g] <= dcnt_pkg::COMP_DEF;
			end else if (ctrl_q[g][dcnt_pkg::CTRL_XCHG]) begin
				app_ctrl_q[g] <= ctrl_q[g][2:0];
				app_pend_q[g] <= pend_q[g];
				snap_count_q[g] <= cnt_val[g];
				snap_comp_q[g] <= cmp_val[g];
			end
		end
	end

	// Write channel: address and data are taken in either order
	logic aw_full_q, w_full_q, bvalid_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write, wr_hit, wr_bank;
	logic [2:0] wr_idx;

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign wr_idx = aw_addr_q[dcnt_pkg::IDX_MSB:dcnt_pkg::IDX_LSB];
	assign wr_bank = aw_addr_q[dcnt_pkg::BANK_BIT];
	assign wr_hit = (aw_addr_q[7:dcnt_pkg::BANK_BIT+1] == '0) && (wr_idx != 3'(dcnt_pkg::MAP_TOP));

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			s_axi_bresp <= dcnt_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			s_axi_bresp <= wr_hit ? dcnt_pkg::RESP_OKAY : dcnt_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;

	// Register writes; read-only words accept and drop the data
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < N; i++) begin
				ctrl_q[i] <= dcnt_pkg::CTRL_RST_VAL;
				cfg_q[i] <= dcnt_pkg::CFG_RST_VAL;
				rstval_q[i] <= dcnt_pkg::RSTVAL_DEF;
				pend_q[i] <= dcnt_pkg::PEND_DEF;
			end
		end else if (do_write && wr_hit) begin
			case (wr_idx)
				dcnt_pkg::IDX_CTRL: begin
					ctrl_q[wr_bank] <= 4'(merge(32'(ctrl_q[wr_bank]), w_data_q, w_strb_q));
				end
				dcnt_pkg::IDX_CFG: begin
					cfg_q[wr_bank] <= 10'(merge(32'(cfg_q[wr_bank]), w_data_q, w_strb_q));
				end
				dcnt_pkg::IDX_RSTVAL: begin
					rstval_q[wr_bank] <= merge(rstval_q[wr_bank], w_data_q, w_strb_q);
				end
				dcnt_pkg::IDX_PEND: begin
					pend_q[wr_bank] <= merge(pend_q[wr_bank], w_data_q, w_strb_q);
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel: one cycle from address to data
	logic rvalid_q, rd_hit, rd_bank;
	logic [2:0] rd_idx;
	logic [31:0] rd_word;

	assign s_axi_arready = !rvalid_q;
	assign rd_idx = s_axi_araddr[dcnt_pkg::IDX_MSB:dcnt_pkg::IDX_LSB];
	assign rd_bank = s_axi_araddr[dcnt_pkg::BANK_BIT];
	assign rd_hit = (s_axi_araddr[7:dcnt_pkg::BANK_BIT+1] == '0) && (rd_idx != 3'(dcnt_pkg::MAP_TOP));

	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			dcnt_pkg::IDX_CTRL: rd_word = 32'(ctrl_q[rd_bank]);
			dcnt_pkg::IDX_CFG: rd_word = 32'(cfg_q[rd_bank]);
			dcnt_pkg::IDX_RSTVAL: rd_word = rstval_q[rd_bank];
			dcnt_pkg::IDX_PEND: rd_word = pend_q[rd_bank];
			dcnt_pkg::IDX_COUNT: rd_word = snap_count_q[rd_bank];
			dcnt_pkg::IDX_COMP: rd_word = snap_comp_q[rd_bank];
			dcnt_pkg::IDX_STATUS: rd_word = 32'(outs[rd_bank]);
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dcnt_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
			s_axi_rresp <= rd_hit ? dcnt_pkg::RESP_OKAY : dcnt_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
endmodule // dcnt_top

// file: test/dcnt_top_asserts.sv
// Purpose: Port checks for the dual compare counter.
// Assumes: One core_clk domain, nrst async active low.
// Notes: Output rises must trace to a recent own pin edge; a_out falls to a recent pin edge or register write.
`timescale 1ns/1ps
module dcnt_top_asserts (
	input wire logic core_clk, // Clock
	input wire logic nrst, // Reset
	input wire logic a_up_pulse, // Pin
	input wire logic a_down_dir, // Pin
	input wire logic b_up_pulse, // Pin
	input wire logic b_down_dir, // Pin
	input wire logic a_out, // Output
	input wire logic b_out, // Output
	input wire logic s_axi_awvalid, // Bus
	input wire logic s_axi_awready, // Bus
	input wire logic s_axi_wvalid, // Bus
	input wire logic s_axi_wready, // Bus
	input wire logic s_axi_bvalid, // Bus
	input wire logic s_axi_bready, // Bus
	input wire logic s_axi_arvalid, // Bus
	input wire logic s_axi_arready, // Bus
	input wire logic [31:0] s_axi_rdata, // Bus
	input wire logic [1:0] s_axi_rresp, // Bus
	input wire logic s_axi_rvalid, // Bus
	input wire logic s_axi_rready // Bus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [3:0] pin_q;
	logic [3:0] age_a_q;
	logic [3:0] age_b_q;
	logic [3:0] age_w_q;
	// Ages saturate so a long idle never wraps back into the window
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_q <= 4'h0;
			age_a_q <= 4'hf;
			age_b_q <= 4'hf;
			age_w_q <= 4'hf;
		end else begin
			pin_q <= {a_up_pulse, a_down_dir, b_up_pulse, b_down_dir};
			age_a_q <= (|({a_up_pulse, a_down_dir} & ~pin_q[3:2])) ? 4'h0 : age_a_q + 4'(age_a_q != 4'hf);
			age_b_q <= (|({b_up_pulse, b_down_dir} & ~pin_q[1:0])) ? 4'h0 : age_b_q + 4'(age_b_q != 4'hf);
			age_w_q <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : age_w_q + 4'(age_w_q != 4'hf);
		end
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == dcnt_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	a_rise_a_cause: assert property ($rose(a_out) |-> age_a_q > 4'h0 && age_a_q < 4'h7)
		else $error("output a rose without own pin edge");
	a_fall_a_cause: assert property ($fell(a_out) |-> age_a_q < 4'h7 || age_w_q < 4'h7)
		else $error("output a fell without cause");
	a_rise_b_cause: assert property ($rose(b_out) |-> age_b_q > 4'h0 && age_b_q < 4'h7)
		else $error("output b rose without own pin edge");
endmodule // dcnt_top_asserts

bind dcnt_top dcnt_top_asserts u_chk (.*);

// file: test/dcnt_sensor.sv
// Purpose: Pulse sensor model driving one counter's two pins.
// Assumes: Tasks are called just after a rising core_clk edge.
// Notes: Direction waits are long, so they are a parameter.
`timescale 1ns/1ps
module dcnt_sensor #(
	parameter int DIR_GAP = 2500, // 100 us at 25 MHz
	parameter int HALF = 4 // Cycles high per pulse
) (
	input wire logic core_clk, // Clock
	output logic up_pulse, // Up or pulse pin
	output logic down_dir // Down or direction pin
);
	initial begin
		up_pulse = 1'b0;
		down_dir = 1'b0;
	end
	// Pulses stay above three cycles each way so the synchroniser sees them
	task automatic pulse(input bit on_down, input int n);
		repeat (n) begin
			@(posedge core_clk);
			up_pulse <= !on_down;
			down_dir <= down_dir | on_down;
			repeat (HALF) @(posedge core_clk);
			up_pulse <= 1'b0;
			down_dir <= down_dir & !on_down;
			repeat (HALF) @(posedge core_clk);
		end
	endtask
	task automatic set_dir(input logic d);
		repeat (DIR_GAP) @(posedge core_clk);
		down_dir <= d;
		repeat (DIR_GAP) @(posedge core_clk);
	endtask
endmodule // dcnt_sensor

// file: test/dcnt_top_test.sv
// Purpose: Self-checking bench for the dual compare counter.
// Assumes: 25 MHz core_clk, registers over AXI4-Lite.
// Notes: Counter A bank at 0x00, counter B bank at 0x20.
`timescale 1ns/1ps
module dcnt_top_test;
	logic core_clk, nrst, a_up_pulse, a_down_dir, b_up_pulse, b_down_dir, a_out, b_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_total = 0;
	int n_tests = 0;
	dcnt_top uut (.*);
	dcnt_sensor sens_a (.core_clk(core_clk), .up_pulse(a_up_pulse), .down_dir(a_down_dir));
	dcnt_sensor sens_b (.core_clk(core_clk), .up_pulse(b_up_pulse), .down_dir(b_down_dir));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One access at a time; ready stays up until the answer is seen
	task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_bvalid || s_axi_rvalid) break;
		end
		rv = s_axi_rdata;
		rr = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (i == 40) begin
			chk("bus answer", 32'h0, 32'h1);
			print_verdict();
		end
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rv, exp);
	endtask
	task automatic t_reset();
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) begin
				bus(1'b0, 8'(j * 32 + i * 4), 32'h0);
				chk("reset word", rv, (i == 0) ? 32'(dcnt_pkg::CTRL_RST_VAL) : 32'h0);
				chk("read resp", 32'(rr), (i == 7) ? 32'(dcnt_pkg::RESP_SLVERR) : 32'h0);
			end
		end
		bus(1'b1, 8'h1c, 32'h0);
		chk("unmapped write resp", 32'(rr), 32'(dcnt_pkg::RESP_SLVERR));
		bus(1'b1, 8'h10, 32'h5);
		chk("ro write resp", 32'(rr), 32'(dcnt_pkg::RESP_OKAY));
		rchk("ro write ignored", 8'h10, 32'h0);
		$display("Test reset done");
	endtask
	task automatic t_gate();
		sens_a.pulse(1'b0, 3);
		rchk("gated count", 8'h10, 32'h0);
		bus(1'b1, 8'h00, 32'h9);
		bus(1'b1, 8'h20, 32'h9);
		bus(1'b1, 8'h24, 32'h10);
		sens_a.pulse(1'b0, 3);
		sens_a.pulse(1'b1, 1);
		sens_b.pulse(1'b1, 1);
		rchk("count a", 8'h10, 32'h2);
		rchk("count b", 8'h30, 32'hffff_ffff);
		chk("out b", 32'(b_out), 32'h1);
		rchk("status b", 8'h38, 32'h1);
		$display("Test gate done");
	endtask
	task automatic t_dir();
		bus(1'b1, 8'h04, 32'h1);
		sens_a.set_dir(1'b1);
		sens_a.pulse(1'b0, 2);
		sens_a.set_dir(1'b0);
		sens_a.pulse(1'b0, 3);
		rchk("pulse dir", 8'h10, 32'h1);
		rchk("b untouched", 8'h30, 32'hffff_ffff);
		bus(1'b1, 8'h04, 32'h0);
		$display("Test direction done");
	endtask
	task automatic t_cmp();
		logic o;
		logic [1:0] seq [5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
		bus(1'b1, 8'h08, 32'h7fff_fffe);
		bus(1'b1, 8'h00, 32'hb);
		sens_a.pulse(1'b0, 1);
		rchk("held count", 8'h10, 32'h7fff_fffe);
		bus(1'b1, 8'h0c, 32'h7fff_ffff);
		bus(1'b1, 8'h00, 32'hd);
		bus(1'b1, 8'h00, 32'h9);
		rchk("loaded comp", 8'h14, 32'h7fff_ffff);
		o = 1'b0;
		foreach (seq[k]) begin
			bus(1'b1, 8'h04, 32'(seq[k]) << 2);
			sens_a.pulse(1'b0, 1);
			o = (seq[k] == 2'h1) || (seq[k] == 2'h2 && !o) || (seq[k] == 2'h0 && o);
			chk("reaction", 32'(a_out), 32'(o));
			sens_a.pulse(1'b1, 1);
		end
		bus(1'b1, 8'h0c, 32'h5);
		bus(1'b1, 8'h04, 32'h104);
		sens_a.pulse(1'b0, 2);
		rchk("event comp", 8'h14, 32'h5);
		rchk("wrap", 8'h10, 32'h8000_0000);
		bus(1'b1, 8'h00, 32'h1);
		sens_a.pulse(1'b0, 2);
		bus(1'b1, 8'h00, 32'h9);
		repeat (2) @(posedge core_clk);
		rchk("free run", 8'h10, 32'h8000_0002);
		chk("out on", 32'(a_out), 32'h1);
		bus(1'b1, 8'h00, 32'hb);
		sens_a.pulse(1'b0, 1);
		chk("out forced", 32'(a_out), 32'h0);
		rchk("status a", 8'h18, 32'h0);
		rchk("held again", 8'h10, 32'h7fff_fffe);
		$display("Test compare done");
	endtask
	// Counter B: event reset on reach and fall, event load on fall
	task automatic t_event();
		bus(1'b1, 8'h28, 32'h20);
		bus(1'b1, 8'h24, 32'h48);
		sens_b.pulse(1'b0, 1);
		rchk("reach reset", 8'h30, 32'h20);
		chk("reach toggle", 32'(b_out), 32'h0);
		bus(1'b1, 8'h2c, 32'h20);
		bus(1'b1, 8'h20, 32'hd);
		bus(1'b1, 8'h20, 32'h9);
		bus(1'b1, 8'h2c, 32'h3);
		bus(1'b1, 8'h24, 32'h2a0);
		sens_b.pulse(1'b1, 1);
		rchk("fall reset", 8'h30, 32'h20);
		rchk("fall load", 8'h34, 32'h3);
		chk("fall toggle", 32'(b_out), 32'h1);
		$display("Test events done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_gate();
		t_dir();
		t_cmp();
		t_event();
		print_verdict();
	end
endmodule // dcnt_top_test
